// File: logic/cbu_branch_unit.sv
`include "cbu_map.svh"
`default_nettype none
module cbu_branch_unit
  import cbu_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Decoded branch request and flag register
  input wire cbu_pkg::cbu_req_type i_req,
  input wire logic [7:0] i_flag_register,
  // Result to fetch stage
  output logic [15:0] o_next_pc,
  output logic o_resp_valid,
  output logic o_taken,
  output logic o_flush,
  output logic o_busy,
  output logic [7:0] o_flag_register
);
  import cbu_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_meta_reg;
  logic rst_n_reg;
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------
  // Condition evaluation
  // ----------------------------------------
  function automatic logic flag_at(input logic [7:0] f, input logic [2:0] idx);
    flag_at = f[idx];
  endfunction

  logic cond;
  always_comb begin
    cond = 1'b0;
    unique case (i_req.op)
      CBU_OP_NONE: cond = 1'b0;
      CBU_OP_FLAG_SET: cond = flag_at(i_flag_register, i_req.bit_sel);
      CBU_OP_FLAG_CLEAR: cond = !flag_at(i_flag_register, i_req.bit_sel);
      CBU_OP_EQUAL: cond = flag_at(i_flag_register, `CBU_FLAG_Z);
      CBU_OP_NOT_EQUAL: cond = !flag_at(i_flag_register, `CBU_FLAG_Z);
      CBU_OP_CARRY_SET, CBU_OP_LOWER: begin
        cond = flag_at(i_flag_register, `CBU_FLAG_C);
      end
      CBU_OP_CARRY_CLEAR, CBU_OP_SAME_HIGHER: begin
        cond = !flag_at(i_flag_register, `CBU_FLAG_C);
      end
      CBU_OP_NEGATIVE: cond = flag_at(i_flag_register, `CBU_FLAG_N);
      CBU_OP_POSITIVE: cond = !flag_at(i_flag_register, `CBU_FLAG_N);
      CBU_OP_SIGNED_GE: begin
        cond = !(i_flag_register[`CBU_FLAG_N] ^ i_flag_register[`CBU_FLAG_V]);
      end
      CBU_OP_SIGNED_LT: begin
        cond = i_flag_register[`CBU_FLAG_N] ^ i_flag_register[`CBU_FLAG_V];
      end
      CBU_OP_HALF_SET: cond = flag_at(i_flag_register, `CBU_FLAG_H);
      CBU_OP_HALF_CLEAR: cond = !flag_at(i_flag_register, `CBU_FLAG_H);
      CBU_OP_TRANSFER_SET: cond = flag_at(i_flag_register, `CBU_FLAG_T);
      CBU_OP_TRANSFER_CLEAR: cond = !flag_at(i_flag_register, `CBU_FLAG_T);
      CBU_OP_OVERFLOW_SET: cond = flag_at(i_flag_register, `CBU_FLAG_V);
      CBU_OP_OVERFLOW_CLEAR: cond = !flag_at(i_flag_register, `CBU_FLAG_V);
      default: cond = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Target arithmetic
  // ----------------------------------------
  // Offset is signed words; sign extend before the add
  logic [15:0] ofs_ext;
  logic [15:0] target_pc;
  logic [15:0] seq_pc;
  assign ofs_ext = {{9{i_req.offset[6]}}, i_req.offset};
  assign target_pc = 16'(i_req.pc + ofs_ext + 16'h0001);
  assign seq_pc = 16'(i_req.pc + 16'h0001);

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  cbu_state_type state_reg;
  logic accept;
  assign accept = i_req.valid && (state_reg == CBU_ST_RUN) && (i_req.op != CBU_OP_NONE);

  // Taken branch spends a second cycle flushing the fetched word
  always_ff @(posedge i_mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= CBU_ST_RUN;
    end else begin
      unique case (state_reg)
        CBU_ST_RUN: if (accept && cond) state_reg <= CBU_ST_FLUSH;
        CBU_ST_FLUSH: state_reg <= CBU_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_next_pc <= `CBU_PC_RST;
      o_resp_valid <= 1'b0;
      o_taken <= 1'b0;
    end else begin
      o_resp_valid <= accept;
      if (accept) begin
        o_taken <= cond;
        o_next_pc <= cond ? target_pc : seq_pc;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_flush <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_flush <= accept && cond;
      o_busy <= accept && cond;
    end
  end

  // Flags pass through untouched, branches never write them
  always_ff @(posedge i_mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      o_flag_register <= `CBU_FLAGS_RST;
    end else begin
      o_flag_register <= i_flag_register;
    end
  end

  // ----------------------------------------
  // Turnaround tracking
  // ----------------------------------------
  // Checker-only age of the last taken branch, saturating at 3
  logic [1:0] gap_reg;
  logic [1:0] gap_next;
  always_comb begin
    gap_next = gap_reg;
    if (accept && cond) begin
      gap_next = 2'h1;
    end else if (gap_reg != 2'h0 && gap_reg != 2'h3) begin
      gap_next = 2'(gap_reg + 2'h1);
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      gap_reg <= 2'h0;
    end else begin
      gap_reg <= gap_next;
    end
  end

  // ----------------------------------------
  // Decode reference
  // ----------------------------------------
  // Table view of the decode, kept apart so a slip in either one shows
  function automatic logic [2:0] ref_flag(input cbu_op_type op, input logic [2:0] sel);
    case (op)
      CBU_OP_EQUAL, CBU_OP_NOT_EQUAL: ref_flag = `CBU_FLAG_Z;
      CBU_OP_CARRY_SET, CBU_OP_CARRY_CLEAR: ref_flag = `CBU_FLAG_C;
      CBU_OP_SAME_HIGHER, CBU_OP_LOWER: ref_flag = `CBU_FLAG_C;
      CBU_OP_NEGATIVE, CBU_OP_POSITIVE: ref_flag = `CBU_FLAG_N;
      CBU_OP_SIGNED_GE, CBU_OP_SIGNED_LT: ref_flag = `CBU_FLAG_N;
      CBU_OP_HALF_SET, CBU_OP_HALF_CLEAR: ref_flag = `CBU_FLAG_H;
      CBU_OP_TRANSFER_SET, CBU_OP_TRANSFER_CLEAR: ref_flag = `CBU_FLAG_T;
      CBU_OP_OVERFLOW_SET, CBU_OP_OVERFLOW_CLEAR: ref_flag = `CBU_FLAG_V;
      default: ref_flag = sel;
    endcase
  endfunction

  function automatic logic ref_level(input cbu_op_type op);
    case (op)
      CBU_OP_FLAG_SET, CBU_OP_EQUAL, CBU_OP_CARRY_SET, CBU_OP_LOWER: ref_level = 1'b1;
      CBU_OP_NEGATIVE, CBU_OP_SIGNED_LT, CBU_OP_HALF_SET: ref_level = 1'b1;
      CBU_OP_TRANSFER_SET, CBU_OP_OVERFLOW_SET: ref_level = 1'b1;
      default: ref_level = 1'b0;
    endcase
  endfunction

  logic ref_bit;
  logic ref_taken;
  always_comb begin
    ref_bit = i_flag_register[ref_flag(i_req.op, i_req.bit_sel)];
    if (i_req.op == CBU_OP_SIGNED_GE || i_req.op == CBU_OP_SIGNED_LT) begin
      ref_bit = ref_bit ^ i_flag_register[`CBU_FLAG_V];
    end
    ref_taken = (i_req.op != CBU_OP_NONE) && (i_req.op <= CBU_OP_OVERFLOW_CLEAR)
      && (ref_bit == ref_level(i_req.op));
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n_reg);

  flag_set_sel_a: assert property (
    accept && i_req.op == CBU_OP_FLAG_SET |=> o_taken == $past(i_flag_register[i_req.bit_sel]))
    else $error("flag-set branch decision wrong");
  flag_clr_sel_a: assert property (
    accept && i_req.op == CBU_OP_FLAG_CLEAR |=> o_taken != $past(i_flag_register[i_req.bit_sel]))
    else $error("flag-clear branch decision wrong");
  equal_zero_a: assert property (
    accept && i_req.op == CBU_OP_EQUAL |=> o_taken == $past(i_flag_register[1]))
    else $error("equal branch decision wrong");
  not_equal_a: assert property (
    accept && i_req.op == CBU_OP_NOT_EQUAL |=> o_taken == !$past(i_flag_register[1]))
    else $error("not-equal branch decision wrong");
  carry_set_a: assert property (
    accept && (i_req.op == CBU_OP_CARRY_SET || i_req.op == CBU_OP_LOWER)
    |=> o_taken == $past(i_flag_register[0]))
    else $error("carry-set branch decision wrong");
  carry_clr_a: assert property (
    accept && (i_req.op == CBU_OP_CARRY_CLEAR || i_req.op == CBU_OP_SAME_HIGHER)
    |=> o_taken == !$past(i_flag_register[0]))
    else $error("carry-clear branch decision wrong");
  negative_a: assert property (
    accept && i_req.op == CBU_OP_NEGATIVE |=> o_taken == $past(i_flag_register[2]))
    else $error("negative branch decision wrong");
  positive_a: assert property (
    accept && i_req.op == CBU_OP_POSITIVE |=> o_taken == !$past(i_flag_register[2]))
    else $error("positive branch decision wrong");
  signed_ge_a: assert property (
    accept && i_req.op == CBU_OP_SIGNED_GE
    |=> o_taken == !$past(i_flag_register[2] ^ i_flag_register[3]))
    else $error("signed ge branch decision wrong");
  signed_lt_a: assert property (
    accept && i_req.op == CBU_OP_SIGNED_LT
    |=> o_taken == $past(i_flag_register[2] ^ i_flag_register[3]))
    else $error("signed lt branch decision wrong");
  half_carry_a: assert property (
    accept && i_req.op == CBU_OP_HALF_SET |=> o_taken == $past(i_flag_register[5]))
    else $error("half carry branch decision wrong");
  transfer_set_a: assert property (
    accept && i_req.op == CBU_OP_TRANSFER_SET |=> o_taken == $past(i_flag_register[6]))
    else $error("transfer-set branch decision wrong");
  transfer_clr_a: assert property (
    accept && i_req.op == CBU_OP_TRANSFER_CLEAR |=> o_taken == !$past(i_flag_register[6]))
    else $error("transfer-clear branch decision wrong");
  overflow_set_a: assert property (
    accept && i_req.op == CBU_OP_OVERFLOW_SET |=> o_taken == $past(i_flag_register[3]))
    else $error("overflow-set branch decision wrong");
  overflow_clr_a: assert property (
    accept && i_req.op == CBU_OP_OVERFLOW_CLEAR |=> o_taken == !$past(i_flag_register[3]))
    else $error("overflow-clear branch decision wrong");
  flags_kept_a: assert property (
    o_resp_valid |-> o_flag_register == $past(i_flag_register))
    else $error("branch altered the flags");
  taken_target_a: assert property (
    accept && cond |=> o_next_pc == 16'($past(i_req.pc) + $past(ofs_ext) + 16'h0001))
    else $error("taken target address wrong");
  taken_two_a: assert property (
    accept && cond |=> o_busy ##1 (!o_busy && state_reg == CBU_ST_RUN))
    else $error("taken branch not two cycles");
  not_taken_one_a: assert property (
    accept && !cond |=> !o_busy && !o_flush && o_next_pc == $past(seq_pc))
    else $error("untaken branch not one cycle");
  half_clear_a: assert property (
    accept && i_req.op == CBU_OP_HALF_CLEAR |=> o_taken == !$past(i_flag_register[5]))
    else $error("half carry clear branch decision wrong");
  flush_pulse_a: assert property (
    o_flush |=> !o_flush)
    else $error("flush longer than one cycle");
  flush_busy_a: assert property (
    o_flush == o_busy)
    else $error("busy and flush disagree");
  flush_taken_a: assert property (
    o_flush == (o_resp_valid && o_taken))
    else $error("flush without a taken answer");
  flush_refuse_a: assert property (
    state_reg == CBU_ST_FLUSH |=> !o_resp_valid)
    else $error("request answered in flush cycle");
  pc_hold_a: assert property (
    !accept |=> $stable(o_next_pc))
    else $error("next pc moved without a branch");
  taken_hold_a: assert property (
    !accept |=> $stable(o_taken))
    else $error("taken moved without a branch");
  reset_clear_a: assert property (
    $rose(rst_n_reg) |-> !o_resp_valid && !o_flush && !o_busy && !o_taken && gap_reg == 2'h0
      && state_reg == CBU_ST_RUN && o_next_pc == `CBU_PC_RST)
    else $error("unit not idle after reset");
  turn_flush_a: assert property (
    gap_reg == 2'h1 |-> state_reg == CBU_ST_FLUSH && o_busy && o_flush)
    else $error("taken branch did not hold the unit");
  turn_free_a: assert property (
    gap_reg == 2'h2 |-> state_reg == CBU_ST_RUN && !o_busy)
    else $error("unit held past the flush cycle");
  ref_decode_a: assert property (
    accept |=> o_taken == $past(ref_taken))
    else $error("branch decision differs from decode table");

  // One set of checks per flag position
  for (genvar b = 0; b < 8; b++) begin : g_bit_chk
    bit_set_a: assert property (
      accept && i_req.op == CBU_OP_FLAG_SET && i_req.bit_sel == 3'(b)
      |=> o_taken == $past(i_flag_register[b]))
      else $error("flag-set branch ignores its bit");
    bit_clear_a: assert property (
      accept && i_req.op == CBU_OP_FLAG_CLEAR && i_req.bit_sel == 3'(b)
      |=> o_taken != $past(i_flag_register[b]))
      else $error("flag-clear branch ignores its bit");
    bit_kept_a: assert property (
      o_resp_valid |-> o_flag_register[b] == $past(i_flag_register[b]))
      else $error("branch altered a flag bit");
  end


  taken_c: cover property (accept && cond);
  not_taken_c: cover property (accept && !cond);
  back_to_back_c: cover property (accept && cond ##2 accept);
  backward_c: cover property (accept && cond && i_req.offset[6]);
  flush_refused_c: cover property (state_reg == CBU_ST_FLUSH && i_req.valid);

endmodule // cbu_branch_unit
`default_nettype wire

// File: logic/cbu_map.svh
`ifndef CBU_MAP_SVH
`define CBU_MAP_SVH
// Flag positions in the flag register
`define CBU_FLAG_C 3'd0
`define CBU_FLAG_Z 3'd1
`define CBU_FLAG_N 3'd2
`define CBU_FLAG_V 3'd3
`define CBU_FLAG_S 3'd4
`define CBU_FLAG_H 3'd5
`define CBU_FLAG_T 3'd6
`define CBU_FLAG_I 3'd7
// Widths
`define CBU_PC_W 16
`define CBU_OFS_W 7
// Reset values
`define CBU_PC_RST 16'h0000
`define CBU_FLAGS_RST 8'h00
// Taken branch costs one extra cycle
`define CBU_TAKEN_CYCLES 2
`endif

// File: logic/cbu_pkg.sv
`default_nettype none
package cbu_pkg;
  typedef enum logic [4:0] {
    CBU_OP_NONE = 5'h00,
    CBU_OP_FLAG_SET = 5'h01,
    CBU_OP_FLAG_CLEAR = 5'h02,
    CBU_OP_EQUAL = 5'h03,
    CBU_OP_NOT_EQUAL = 5'h04,
    CBU_OP_CARRY_SET = 5'h05,
    CBU_OP_CARRY_CLEAR = 5'h06,
    CBU_OP_SAME_HIGHER = 5'h07,
    CBU_OP_LOWER = 5'h08,
    CBU_OP_NEGATIVE = 5'h09,
    CBU_OP_POSITIVE = 5'h0a,
    CBU_OP_SIGNED_GE = 5'h0b,
    CBU_OP_SIGNED_LT = 5'h0c,
    CBU_OP_HALF_SET = 5'h0d,
    CBU_OP_HALF_CLEAR = 5'h0e,
    CBU_OP_TRANSFER_SET = 5'h0f,
    CBU_OP_TRANSFER_CLEAR = 5'h10,
    CBU_OP_OVERFLOW_SET = 5'h11,
    CBU_OP_OVERFLOW_CLEAR = 5'h12
  } cbu_op_type;
  typedef enum logic [0:0] {
    CBU_ST_RUN = 1'b0,
    CBU_ST_FLUSH = 1'b1
  } cbu_state_type;
  typedef struct packed {
    logic valid;
    cbu_op_type op;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    logic [15:0] pc;
  } cbu_req_type;
  typedef struct packed {
    logic valid;
    logic taken;
    logic [15:0] next_pc;
  } cbu_resp_type;
endpackage
`default_nettype wire

// File: verif/cbu_fetch_model.sv
`default_nettype none
module cbu_fetch_model (
  // Commands from the bench
  input wire logic i_go,
  input wire cbu_pkg::cbu_op_type i_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [6:0] i_offset,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_flags,
  // Toward the branch unit
  output cbu_pkg::cbu_req_type o_req,
  output logic [7:0] o_flag_register
);
  timeunit 1ns;
  timeprecision 100ps;
  import cbu_pkg::*;
  // ----------------------------------------
  // Fetch bus
  // ----------------------------------------
  // Idle bus shows inverted fields so stale values never pass for live ones
  always_comb begin
    o_req.valid = i_go;
    o_req.op = i_go ? i_op : cbu_op_type'(~i_op);
    o_req.bit_sel = i_go ? i_bit_sel : ~i_bit_sel;
    o_req.offset = i_go ? i_offset : ~i_offset;
    o_req.pc = i_go ? i_pc : ~i_pc;
  end
  // Flag register is a level the core always presents
  assign o_flag_register = i_flags;
endmodule // cbu_fetch_model
`default_nettype wire

// File: verif/tb_conditional_branch_unit.sv
`include "cbu_map.svh"
`default_nettype none
module tb_conditional_branch_unit;
  timeunit 1ns;
  timeprecision 100ps;
  import cbu_pkg::*;
  logic i_mclk = 1'b0;
  logic i_arst_n = 1'b0;
  logic go = 1'b0;
  cbu_op_type op = CBU_OP_NONE;
  logic [2:0] bsel = 3'h0;
  logic [6:0] ofs = 7'h00;
  logic [15:0] pc = 16'h0000;
  logic [7:0] flags = 8'h00;
  cbu_req_type req;
  logic [7:0] flag_bus;
  logic [15:0] o_next_pc;
  logic o_resp_valid, o_taken, o_flush, o_busy;
  logic [7:0] o_flag_register;
  int failures = 0;
  int check_count = 0;
  always #2.5 i_mclk = ~i_mclk;
  cbu_fetch_model u_model (.i_go(go), .i_op(op), .i_bit_sel(bsel), .i_offset(ofs),
    .i_pc(pc), .i_flags(flags), .o_req(req), .o_flag_register(flag_bus));
  cbu_branch_unit u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_req(req),
    .i_flag_register(flag_bus), .o_next_pc(o_next_pc), .o_resp_valid(o_resp_valid),
    .o_taken(o_taken), .o_flush(o_flush), .o_busy(o_busy), .o_flag_register(o_flag_register));
  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic cond(cbu_op_type o, logic [7:0] f, logic [2:0] b);
    case (o)
      CBU_OP_FLAG_SET: return f[b];
      CBU_OP_FLAG_CLEAR: return !f[b];
      CBU_OP_EQUAL: return f[`CBU_FLAG_Z];
      CBU_OP_NOT_EQUAL: return !f[`CBU_FLAG_Z];
      CBU_OP_CARRY_SET, CBU_OP_LOWER: return f[`CBU_FLAG_C];
      CBU_OP_CARRY_CLEAR, CBU_OP_SAME_HIGHER: return !f[`CBU_FLAG_C];
      CBU_OP_NEGATIVE: return f[`CBU_FLAG_N];
      CBU_OP_POSITIVE: return !f[`CBU_FLAG_N];
      CBU_OP_SIGNED_GE: return !(f[`CBU_FLAG_N] ^ f[`CBU_FLAG_V]);
      CBU_OP_SIGNED_LT: return f[`CBU_FLAG_N] ^ f[`CBU_FLAG_V];
      CBU_OP_HALF_SET: return f[`CBU_FLAG_H];
      CBU_OP_HALF_CLEAR: return !f[`CBU_FLAG_H];
      CBU_OP_TRANSFER_SET: return f[`CBU_FLAG_T];
      CBU_OP_TRANSFER_CLEAR: return !f[`CBU_FLAG_T];
      CBU_OP_OVERFLOW_SET: return f[`CBU_FLAG_V];
      CBU_OP_OVERFLOW_CLEAR: return !f[`CBU_FLAG_V];
      default: return 1'b0;
    endcase
  endfunction
  // Called at a rising edge; returns three edges later, one edge after a taken branch has left the unit idle again
  task automatic branch(cbu_op_type o, logic [2:0] b, logic [6:0] k, logic [15:0] p,
                        logic [7:0] f);
    logic t;
    logic [15:0] npc;
    t = cond(o, f, b);
    npc = t ? p + {{9{k[6]}}, k} + 16'h0001 : p + 16'h0001;
    go <= 1'b1;
    op <= o;
    bsel <= b;
    ofs <= k;
    pc <= p;
    flags <= f;
    @(posedge i_mclk);
    go <= 1'b0;
    #1;
    chk("resp_valid", 16'h0001, o_resp_valid);
    chk("taken", t, o_taken);
    chk("next_pc", npc, o_next_pc);
    chk("flush", t, o_flush);
    chk("busy", t, o_busy);
    chk("flags", f, o_flag_register);
    @(posedge i_mclk);
    #1;
    chk("resp_drop", 16'h0000, o_resp_valid);
    @(posedge i_mclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_all_ops();
    logic [7:0] pat[4] = '{8'h00, 8'hff, 8'h55, 8'haa};
    logic [6:0] ks[4] = '{7'h3f, 7'h40, 7'h01, 7'h7f};
    logic [15:0] ps[4] = '{16'h1000, 16'h0020, 16'hfffe, 16'h8000};
    for (int o = 1; o <= 18; o++) begin
      for (int i = 0; i < 4; i++) begin
        branch(cbu_op_type'(o), 3'(o + i), ks[i], ps[i], pat[i]);
      end
    end
    $display("test all_ops done");
  endtask
  task automatic test_bit_index();
    for (int b = 0; b < 8; b++) begin
      branch(CBU_OP_FLAG_SET, 3'(b), 7'h05, 16'h0100, 8'h01 << b);
      branch(CBU_OP_FLAG_SET, 3'(b), 7'h05, 16'h0100, ~(8'h01 << b));
      branch(CBU_OP_FLAG_CLEAR, 3'(b), 7'h7b, 16'h0100, ~(8'h01 << b));
    end
    $display("test bit_index done");
  endtask
  task automatic test_pipeline();
    go <= 1'b1;
    op <= CBU_OP_EQUAL;
    flags <= 8'h00;
    ofs <= 7'h10;
    pc <= 16'h0200;
    @(posedge i_mclk);
    pc <= 16'h0300;
    #1;
    chk("b2b first", 16'h0201, o_next_pc);
    @(posedge i_mclk);
    op <= CBU_OP_NOT_EQUAL;
    pc <= 16'h0400;
    #1;
    chk("b2b second", 16'h0001, o_resp_valid);
    chk("b2b second pc", 16'h0301, o_next_pc);
    @(posedge i_mclk);
    pc <= 16'h0500;
    #1;
    chk("taken pc", 16'h0411, o_next_pc);
    chk("busy", 16'h0001, o_busy);
    @(posedge i_mclk);
    go <= 1'b0;
    #1;
    chk("flush refusal", 16'h0000, o_resp_valid);
    chk("pc held", 16'h0411, o_next_pc);
    @(posedge i_mclk);
    go <= 1'b1;
    op <= CBU_OP_NONE;
    @(posedge i_mclk);
    go <= 1'b0;
    #1;
    chk("none ignored", 16'h0000, o_resp_valid);
    @(posedge i_mclk);
    $display("test pipeline done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    failures++;
    $display("watchdog expired");
    wrap_up();
  end
  initial begin
    repeat (6) @(posedge i_mclk);
    chk("reset resp", 16'h0000, o_resp_valid);
    i_arst_n <= 1'b1;
    repeat (3) @(posedge i_mclk);
    test_all_ops();
    test_bit_index();
    test_pipeline();
    wrap_up();
  end
endmodule // tb_conditional_branch_unit
`default_nettype wire
